// ### ppg_pkg.sv
/*
 * Package for the cascaded timer pulse generator: APB offsets, field positions,
 * reset values and prescaler taps.
 * Assumes a 32-bit APB with word-aligned registers.
 */
package ppg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] off_control       = 8'h00;
    localparam logic [7:0] off_mode          = 8'h04;
    localparam logic [7:0] off_period_low    = 8'h08;
    localparam logic [7:0] off_period_high   = 8'h0C;
    localparam logic [7:0] off_duty_low      = 8'h10;
    localparam logic [7:0] off_duty_high     = 8'h14;
    localparam logic [7:0] off_system        = 8'h18;
    localparam logic [7:0] off_status        = 8'h1C;
    localparam logic [7:0] off_irq_mask      = 8'h20;
    localparam logic [7:0] off_count         = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ctl_cascade_pos   = 0;
    localparam int ctl_run_pos       = 1;
    localparam int mode_clk_lsb      = 0;
    localparam int mode_clk_msb      = 2;
    localparam int mode_int_clk_pos  = 3;
    localparam int mode_op_lsb       = 4;
    localparam int mode_op_msb       = 5;
    localparam int mode_ext_clk_pos  = 6;
    localparam int mode_init_pos     = 7;
    localparam int mode_dbuf_pos     = 8;
    localparam int sys_div_pos       = 0;
    localparam int sys_slow_pos      = 1;
    localparam int irq_duty_pos      = 0;
    localparam int irq_period_pos    = 1;

    localparam logic [1:0]  op_mode_ppg    = 2'b11;
    localparam logic [8:0]  mode_reset     = 9'h000;
    localparam logic [7:0]  byte_reset     = 8'hFF;
    localparam logic [15:0] count_zero     = 16'h0000;
    localparam logic [31:0] read_zero      = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Prescaler taps (bit index of the free-running divider, -1 for every cycle; tap_slow indexes the divider stepped by fs_tick)
    // ------------------------------------------------------------------
    localparam int div_width = 12;
    localparam int tap_fast [8] = '{10, 9, 7, 5, 3, 1, 0, -1};
    localparam int tap_slow [3] = '{3, 2, 1};

endpackage : ppg_pkg

// ### clock_source_select.sv
/*
 * Source clock selector: produces a one-cycle count tick from the prescaler
 * taps, the low-frequency clock taps, or the synchronised external pin.
 * Assumes fs_tick pulses one cycle per low-frequency clock period.
 */
module clock_source_select
    import ppg_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] clock_select_field,
    input  wire logic       use_external,
    input  wire logic       use_slow,
    input  wire logic       fs_tick,
    input  wire logic       ext_clock_pin,
    output logic            count_tick
);

    logic [div_width-1:0] fast_div;
    logic [div_width-1:0] slow_div;
    logic [div_width-1:0] next_fast_div;
    logic [div_width-1:0] next_slow_div;
    logic                 ext_meta;
    logic                 ext_sync;
    logic                 ext_prev;
    logic [7:0]           fast_tick;
    logic [2:0]           slow_tick;
    logic                 slow_code;
    logic [1:0]           slow_index;
    logic                 ext_rise;
    logic                 int_tick;

    assign next_fast_div = fast_div + div_width'(1);
    assign next_slow_div = fs_tick ? slow_div + div_width'(1) : slow_div;

    // ------------------------------------------------------------------
    // Tick decode
    // ------------------------------------------------------------------
    // prescaler tap select
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_fast
            if (tap_fast[i] < 0)
            begin : g_full
                assign fast_tick[i] = 1'b1;
            end
            else
            begin : g_div
                assign fast_tick[i] = &fast_div[tap_fast[i]:0];
            end
        end
        for (genvar j = 0; j < 3; j++)
        begin : g_slow
            assign slow_tick[j] = fs_tick & (&slow_div[tap_slow[j]:0]);
        end
    endgenerate

    assign slow_code  = (clock_select_field == 3'h0) | (clock_select_field == 3'h1)
                      | (clock_select_field == 3'h7);
    assign slow_index = (clock_select_field == 3'h7) ? 2'h2 : clock_select_field[1:0];
    assign int_tick   = (use_slow & slow_code) ? slow_tick[slow_index]
                      : (use_slow ? 1'b0 : fast_tick[clock_select_field]);
    assign ext_rise   = ext_sync & ~ext_prev;
    assign count_tick = use_external ? ext_rise : int_tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_div <= '0;
            slow_div <= '0;
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            fast_div <= next_fast_div;
            slow_div <= next_slow_div;
            ext_meta <= ext_clock_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

endmodule : clock_source_select

// ### cascaded_timer_pulse_generator.sv
/*
 * Cascaded 16-bit timer in pulse generator mode with an APB register file.
 * Assumes synchronous inputs on pclk and an external fs_tick strobe.
 */
// Local design decisions: register access over APB and the register offsets.
module cascaded_timer_pulse_generator
    import ppg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fs_tick,
    input  wire logic        ext_clock_pin,
    input  wire logic        function_output_enable,
    output logic             pulse_output_pin,
    output logic             pulse_output_enable,
    output logic             low_timer_interrupt,
    output logic             high_timer_interrupt,
    output logic             irq
);

    logic [1:0]  timer_pair_control;
    logic [8:0]  high_mode_register;
    logic [1:0]  system_control_one;
    logic [7:0]  period_low_byte;
    logic [7:0]  period_high_byte;
    logic [7:0]  duty_low_byte;
    logic [15:0] period_buffer;
    logic [15:0] duty_buffer;
    logic [15:0] period_compare_value;
    logic [15:0] duty_compare_value;
    logic [15:0] counter;
    logic        level;
    logic        buffer_pending;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;

    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        wr_duty_high;
    logic        cascade_bit;
    logic        high_run_bit;
    logic        ppg_active;
    logic        initial_level_bit;
    logic        double_buffer_enable;
    logic        use_external;
    logic        use_slow;
    logic        count_tick;
    logic        duty_match;
    logic        period_match;
    logic [15:0] written_period;
    logic [15:0] written_duty;
    logic [15:0] next_counter;
    logic [1:0]  irq_event;
    logic [31:0] read_mux;
    logic        sel_control;
    logic        sel_mode;
    logic        sel_system;
    logic        sel_period_low;
    logic        sel_period_high;
    logic        sel_duty_low;
    logic        sel_irq_mask;
    logic        status_read;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign addr_ok  = (paddr <= off_count) & (paddr[1:0] == 2'b00);
    assign pslverr  = psel & penable & ~addr_ok;
    assign wr_duty_high = wr_en & (paddr == off_duty_high);

    // ------------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------------
    assign sel_control     = wr_en & (paddr == off_control);
    assign sel_mode        = wr_en & (paddr == off_mode);
    assign sel_system      = wr_en & (paddr == off_system);
    assign sel_period_low  = wr_en & (paddr == off_period_low);
    assign sel_period_high = wr_en & (paddr == off_period_high);
    assign sel_duty_low    = wr_en & (paddr == off_duty_low);
    assign sel_irq_mask    = wr_en & (paddr == off_irq_mask);
    assign status_read     = rd_en & (paddr == off_status);

    assign cascade_bit          = timer_pair_control[ctl_cascade_pos];
    assign high_run_bit         = timer_pair_control[ctl_run_pos];
    assign initial_level_bit    = high_mode_register[mode_init_pos];
    assign double_buffer_enable = high_mode_register[mode_dbuf_pos];
    assign ppg_active = cascade_bit & high_run_bit
                      & (high_mode_register[mode_op_msb:mode_op_lsb] == op_mode_ppg);
    assign use_external = high_mode_register[mode_ext_clk_pos]
                        & high_mode_register[mode_int_clk_pos];
    assign use_slow = system_control_one[sys_div_pos] | system_control_one[sys_slow_pos];

    assign written_period = {period_high_byte, period_low_byte};
    assign written_duty   = {pwdata[7:0], duty_low_byte};

    assign duty_match   = ppg_active & count_tick & (next_counter == duty_compare_value);
    assign period_match = ppg_active & count_tick & (next_counter == period_compare_value);
    assign next_counter = counter + 16'h0001;
    assign irq_event    = {period_match, duty_match};

    clock_source_select u_clock_source_select
    (
        .pclk               (pclk),
        .presetn            (presetn),
        .clock_select_field (high_mode_register[mode_clk_msb:mode_clk_lsb]),
        .use_external       (use_external),
        .use_slow           (use_slow),
        .fs_tick            (fs_tick),
        .ext_clock_pin      (ext_clock_pin),
        .count_tick         (count_tick)
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    assign read_mux =
        (paddr == off_control)     ? {30'h0000_0000, timer_pair_control} :
        (paddr == off_mode)        ? {23'h00_0000, high_mode_register} :
        (paddr == off_period_low)  ? {24'h00_0000, period_low_byte} :
        (paddr == off_period_high) ? {24'h00_0000, period_high_byte} :
        (paddr == off_duty_low)    ? {24'h00_0000, duty_low_byte} :
        (paddr == off_duty_high)   ? {24'h00_0000, duty_buffer[15:8]} :
        (paddr == off_system)      ? {30'h0000_0000, system_control_one} :
        (paddr == off_status)      ? {30'h0000_0000, irq_status} :
        (paddr == off_irq_mask)    ? {30'h0000_0000, irq_mask} :
        (paddr == off_count)       ? {16'h0000, counter} : read_zero;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= read_zero;
        else if (psel & ~penable & ~pwrite)
            prdata <= read_mux;
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_pair_control <= 2'h0;
            high_mode_register <= mode_reset;
            system_control_one <= 2'h0;
            period_low_byte    <= byte_reset;
            period_high_byte   <= byte_reset;
            duty_low_byte      <= byte_reset;
            irq_mask           <= 2'h0;
        end
        else if (wr_en)
        begin
            if (sel_control)
                timer_pair_control <= pwdata[1:0];
            if (sel_mode)
                high_mode_register <= pwdata[8:0];
            if (sel_system)
                system_control_one <= pwdata[1:0];
            if (sel_period_low)
                period_low_byte <= pwdata[7:0];
            if (sel_period_high)
                period_high_byte <= pwdata[7:0];
            if (sel_duty_low)
                duty_low_byte <= pwdata[7:0];
            if (sel_irq_mask)
                irq_mask <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Compare registers and double buffer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            period_buffer        <= {byte_reset, byte_reset};
            duty_buffer          <= {byte_reset, byte_reset};
            period_compare_value <= {byte_reset, byte_reset};
            duty_compare_value   <= {byte_reset, byte_reset};
            buffer_pending       <= 1'b0;
        end
        else if (wr_duty_high)
        begin
            period_buffer <= written_period;
            duty_buffer   <= written_duty;
            if (double_buffer_enable & high_run_bit)
                buffer_pending <= 1'b1;
            else
            begin
                period_compare_value <= written_period;
                duty_compare_value   <= written_duty;
                buffer_pending       <= 1'b0;
            end
        end
        else if (period_match & buffer_pending)
        begin
            period_compare_value <= period_buffer;
            duty_compare_value   <= duty_buffer;
            buffer_pending       <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Counter and output
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter <= count_zero;
            level   <= 1'b0;
        end
        else if (!ppg_active)
        begin
            counter <= count_zero;
            level   <= initial_level_bit;
        end
        else if (period_match)
        begin
            counter <= count_zero;
            level   <= initial_level_bit;
        end
        else if (count_tick)
        begin
            counter <= next_counter;
            if (duty_match)
                level <= ~initial_level_bit;
        end
    end

    assign pulse_output_pin     = level;
    assign pulse_output_enable  = function_output_enable;
    assign low_timer_interrupt  = duty_match;
    assign high_timer_interrupt = period_match;

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    // sticky status bits
    generate
        for (genvar b = 0; b <= irq_period_pos; b++)
        begin : g_status
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    irq_status[b] <= 1'b0;
                // A new event wins; a read clears only the bits it reported.
                else if (irq_event[b])
                    irq_status[b] <= 1'b1;
                else if (status_read & prdata[b])
                    irq_status[b] <= 1'b0;
            end
        end
    endgenerate

    assign irq = |(irq_status & irq_mask);

endmodule : cascaded_timer_pulse_generator

// ### ppg_properties.sv
/*
 * Port checker for the cascaded timer pulse generator.
 * Assumes it is bound to the top module and sees only its ports.
 */
module ppg_properties
    import ppg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        fs_tick,
    input  wire logic        ext_clock_pin,
    input  wire logic        function_output_enable,
    input  wire logic        pulse_output_pin,
    input  wire logic        pulse_output_enable,
    input  wire logic        low_timer_interrupt,
    input  wire logic        high_timer_interrupt,
    input  wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [1:0] ctl;
    logic [8:0] md;
    wire        wr  = psel && penable && pwrite;
    wire        act = ctl == 2'h3 && md[mode_op_msb:mode_op_lsb] == op_mode_ppg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) ctl <= 2'h0;
        else if (wr && paddr == off_control) ctl <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) md <= mode_reset;
        else if (wr && paddr == off_mode) md <= pwdata[8:0];
    end

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_oe_follows: assert property (pulse_output_enable == function_output_enable)
        else $error("output enable does not follow port setting");
    a_idle_level: assert property (!act && $past(!act) && $stable(md[mode_init_pos])
        |-> pulse_output_pin == md[mode_init_pos]) else $error("idle level wrong");
    a_irq_active: assert property ((low_timer_interrupt || high_timer_interrupt) |-> act)
        else $error("match event while inactive");
    a_duty_toggle: assert property (low_timer_interrupt && !high_timer_interrupt
        |=> pulse_output_pin != $past(pulse_output_pin)) else $error("no toggle at duty");
    a_period_restore: assert property (high_timer_interrupt
        |=> pulse_output_pin == md[mode_init_pos]) else $error("no restore at period");
    a_irq_rise: assert property ($rose(irq) |-> $past(low_timer_interrupt
        || high_timer_interrupt || (wr && paddr == off_irq_mask))) else $error("irq rose alone");
    a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable
        && (pwrite ? paddr == off_irq_mask : paddr == off_status))) else $error("irq fell alone");
    a_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == read_zero)
        else $error("refused read not zero");
    a_mapped_ok: assert property (psel && penable && paddr <= off_count && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access refused");

    c_duty: cover property (low_timer_interrupt);
    c_period: cover property (high_timer_interrupt);
    c_irq_clear: cover property ($fell(irq));
    c_refused: cover property (pslverr);
endmodule : ppg_properties

bind cascaded_timer_pulse_generator ppg_properties i_ppg_properties (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fs_tick, .ext_clock_pin,
    .function_output_enable, .pulse_output_pin, .pulse_output_enable, .low_timer_interrupt,
    .high_timer_interrupt, .irq);

// ### ppg_far_side.sv
/*
 * Far side model: low-frequency tick source and external timer clock.
 * Assumes one pclk domain; the external clock stands low while not run.
 */
module ppg_far_side
#(
    parameter int fs_div = 5
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ext_run,
    input  wire logic [3:0] half,
    output logic            fs_tick,
    output logic            ext_clock_pin
);
    logic [3:0] fcnt;
    logic [3:0] hcnt;

    assign fs_tick = fcnt == 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) fcnt <= 4'h0;
        else fcnt <= (fcnt == 4'(fs_div - 1)) ? 4'h0 : fcnt + 4'h1;
    end

    // phase width limit: each phase lasts half cycles, half is at least 2.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn || !ext_run)
        begin
            hcnt <= 4'h0;
            ext_clock_pin <= 1'b0;
        end
        else if (hcnt == half - 4'h1)
        begin
            hcnt <= 4'h0;
            ext_clock_pin <= ~ext_clock_pin;
        end
        else hcnt <= hcnt + 4'h1;
    end
endmodule : ppg_far_side

// ### tb.sv
/*
 * Self-checking bench for the cascaded timer pulse generator.
 * Assumes the far side model and the bound port checker.
 */
module tb
    import ppg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fe = 0, ext_run = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000_2957;
    logic [3:0]  half = 4'h2;
    logic        pready, pslverr, fs_tick, ext_clock_pin, pin, oe, lti, hti, irq;
    int          error_cnt = 0, tests_run = 0, cyc = 0, n;
    int          lq[$], hq[$];

    always #5 pclk = ~pclk;

    always @(posedge pclk)
    begin
        cyc++;
        fe <= cyc[3];
        if (lti === 1'b1) lq.push_back(cyc);
        if (hti === 1'b1) hq.push_back(cyc);
        if (cyc > 80000)
        begin
            error_cnt++;
            final_report();
        end
    end

    cascaded_timer_pulse_generator i_cascaded_timer_pulse_generator (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fs_tick,
        .ext_clock_pin, .function_output_enable(fe), .pulse_output_pin(pin),
        .pulse_output_enable(oe), .low_timer_interrupt(lti), .high_timer_interrupt(hti), .irq);
    ppg_far_side #(.fs_div(5)) i_ppg_far_side (.pclk, .presetn, .ext_run, .half, .fs_tick,
        .ext_clock_pin);

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic int exp_div(input int s, input int c);
        int fast[8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};
        int slw[8] = '{16, 8, 0, 0, 0, 0, 0, 4};
        if (s != 0 && slw[c] != 0) return 5 * slw[c];
        return fast[c];
    endfunction : exp_div

    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk("rdata", x, r);
        chk("pslverr", 32'(xe), 32'(e));
    endtask : rd

    task automatic load(input int p, input int d);
        wr(off_period_low, 32'(p & 255));
        wr(off_period_high, 32'(p >> 8));
        wr(off_duty_low, 32'(d & 255));
        wr(off_duty_high, 32'(d >> 8));
    endtask : load

    task automatic measure(input logic [31:0] m, input int dv);
        int          p, d;
        logic [31:0] r;
        r = xs();
        p = 2 + int'(r % 3);
        d = 1 + int'(xs() % (p - 1));
        m[mode_init_pos] = r[8];
        wr(off_control, 32'h1);
        load(p, d);
        wr(off_mode, m);
        lq.delete();
        hq.delete();
        wr(off_control, 32'h3);
        while (hq.size() < 2) @(posedge pclk);
        chk("period", 32'(p * dv), 32'(hq[1] - hq[0]));
        chk("duty", 32'((p - d) * dv), 32'(hq[1] - lq[1]));
        wr(off_control, 32'h1);
        rd(off_count, 32'h0, 1'b0);
        chk("pin", 32'(r[8]), 32'(pin));
    endtask : measure

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) rd(8'(i * 4), (i > 1 && i < 6) ? 32'hFF : 32'h0, 1'b0);
        rd(8'h28, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
        for (int s = 0; s < 3; s++)
            for (int c = 0; c < 8; c++)
                if (s == 0 || c < 2 || c == 7)
                begin
                    wr(off_system, 32'(s));
                    measure(32'h30 | 32'(c), exp_div(s, c));
                end
        wr(off_system, 32'h0);
        ext_run <= 1'b1;
        half <= 4'h3;
        measure(32'h78, 6);
        ext_run <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            wr(off_mode, k ? 32'h37 : 32'h27);
            hq.delete();
            wr(off_control, k ? 32'h2 : 32'h3);
            repeat (50) @(posedge pclk);
            chk("idle", 32'h0, 32'(hq.size()));
            wr(off_control, 32'h1);
        end
        for (int k = 0; k < 2; k++)
        begin
            load(4, 2);
            wr(off_mode, k ? 32'h034 : 32'h134);
            hq.delete();
            wr(off_control, 32'h3);
            while (hq.size() < 1) @(posedge pclk);
            load(6, 3);
            n = hq.size();
            while (hq.size() < n + 2) @(posedge pclk);
            chk("old", k ? 32'd96 : 32'd64, 32'(hq[n] - hq[n - 1]));
            chk("new", 32'd96, 32'(hq[n + 1] - hq[n]));
            wr(off_control, 32'h1);
        end
        wr(off_irq_mask, 32'h0);
        @(negedge pclk);
        chk("irq", 32'h0, 32'(irq));
        wr(off_irq_mask, 32'h3);
        @(negedge pclk);
        chk("irq", 32'h1, 32'(irq));
        rd(off_irq_mask, 32'h3, 1'b0);
        rd(off_status, 32'h3, 1'b0);
        @(negedge pclk);
        chk("irq", 32'h0, 32'(irq));
        rd(off_status, 32'h0, 1'b0);
        final_report();
    end
endmodule : tb
